// File: src/pfc_gate_map.vh
// Register map, field positions, reset values and timing figures of the PFC gate block
`ifndef PFC_GATE_MAP_VH
`define PFC_GATE_MAP_VH
// Clock rate and documented times
`define CLK_HZ         20000000
`define SS_TIMEOUT_MS  1000
`define UVP_SLOW_MS    100
`define BROWNOUT_MS    45
// Register word indices
`define A_CTRL   4'h0
`define A_RAMP_ENHANCED_ON_TIME  4'h1
`define A_ZC     4'h2
`define A_FBLIM  4'h3
`define A_LINE   4'h4
`define A_TON    4'h5
`define A_MODE   4'h6
`define A_REF    4'h7
`define A_STAT   4'h8
`define A_MEAS   4'h9
// Control bits
`define CTRL_EN     0
`define CTRL_OVPL   1
`define CTRL_OCPL   2
`define CTRL_DISC   3
`define CTRL_ADAPT  4
// Reset values
`define CTRL_RST   32'h0000000E
`define RAMP_ENHANCED_ON_TIME_RST  32'h00000104
`define ZC_RST     32'h00002040
`define FBLIM_RST  32'h00C003A0
`define LINE_RST   32'h00A000C0
`define TON_RST    32'h00030100
`define MODE_RST   32'h00300260
`define REF_RST    32'h00020380
// Comparator sync bit positions
`define C_OVP    0
`define C_RAMP_ENHANCED_ON_TIME  1
`define C_CL     2
`define C_HL     3
`define C_ZC     4
`define C_SURGE  5
// Fault bit positions
`define F_OVP  0
`define F_OCP  1
`define F_SS   2
`define F_UVP  3
`define F_FBD  4
`define F_CSD  5
`define F_ZCD  6
// Status: surge flag, write one clears
`define ST_SURGE 16
// Fixed limits of the gate sequencer and the disconnection checks
`define RAMP_ENHANCED_ON_TIME_WAIT   12'h3FF
`define ZC_WAIT_MAX  12'hFFF
`define DISC_COUNT   4'h8
`define FB_STUCK     10'h010
`endif

// File: src/pfc_gate_and_fault_control.v
// PFC boost gate sequencer with comparator handling and protection faults
`timescale 1ns/1ns
`default_nettype none
`include "pfc_gate_map.vh"
module pfc_gate_and_fault_control #(
  parameter [24:0] SS_CYC  = `SS_TIMEOUT_MS * (`CLK_HZ / 1000),
  parameter [24:0] UVP_CYC = `UVP_SLOW_MS * (`CLK_HZ / 1000),
  parameter [24:0] BO_CYC  = `BROWNOUT_MS * (`CLK_HZ / 1000)
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Register port
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // Analog comparators, asynchronous
  input  wire        ovp_cmp,
  input  wire        ramp_enhanced_on_time_cmp,
  input  wire        cycle_limit_cmp,
  input  wire        hard_limit_cmp,
  input  wire        zero_cross_cmp,
  input  wire        surge_cmp,
  // ADC readings and line events, same clock
  input  wire [9:0]  fb_adc,
  input  wire [9:0]  vac_adc,
  input  wire        line_peak,
  input  wire        line_valley,
  // Gate, thresholds, enables, fault and surge flags
  output reg         boost_gate_output,
  output reg  [5:0]  ramp_enhanced_on_time_dac,
  output reg  [7:0]  zc_rise_thr,
  output reg  [7:0]  zc_fall_thr,
  output reg         cs_cmp_en,
  output reg         zc_cmp_en,
  output reg         fault,
  output reg         surge_event
);
  localparam [1:0] S_STOP = 2'b00, S_SS = 2'b01, S_RUN = 2'b10, S_FLT = 2'b11;
  localparam [1:0] G_WAIT = 2'b00, G_PRE = 2'b01, G_TON = 2'b10, G_HOLD = 2'b11;
  localparam [1:0] M_TM = 2'b00, M_VS = 2'b01, M_DCM = 2'b10;

  reg [31:0] ctrl_q, ramp_enhanced_on_time_q, zc_q, fblim_q, line_q, ton_r_q, mode_r_q, ref_q;
  reg [5:0]  s1_q, s2_q;
  reg        zc_prev_q;
  reg [1:0]  sup_q, gst_q, gst_d, mode_q;
  reg [11:0] cnt_q, cnt_d, ton_q;
  reg [3:0]  skip_q, skip_d;
  reg        cyc_ev, cs_lo_ev, cs_hi_ev, zc_miss_ev, zc_ok_ev, start_ok;
  reg [6:0]  f_q, lat_q, f_set, f_lat, f_clr;
  reg [9:0]  vin_peak_q;
  reg        line_ok_q, bo_half_q, hold_q, hl_seen_q, surge_hold_q, surge_flag_q;
  reg [24:0] ss_cnt_q, uvp_cnt_q, bo_cnt_q;
  reg [7:0]  ocp_n_q;
  reg [3:0]  fbd_n_q, csl_n_q, csh_n_q, zcd_n_q;

  // Synchronised comparator levels; only the second stage is read
  wire ovp_s   = s2_q[`C_OVP];
  wire ramp_enhanced_on_time_s = s2_q[`C_RAMP_ENHANCED_ON_TIME];
  wire cl_s    = s2_q[`C_CL];
  wire hl_s    = s2_q[`C_HL];
  wire zc_s    = s2_q[`C_ZC];
  wire surge_s = s2_q[`C_SURGE];
  wire zc_fall = zc_prev_q & ~zc_s;

  // Configuration fields
  wire       en      = ctrl_q[`CTRL_EN];
  wire       disc_en = ctrl_q[`CTRL_DISC];
  wire [9:0] fw_ovp  = fblim_q[9:0];
  wire [9:0] uvp_thr = fblim_q[25:16];
  wire [9:0] bi_thr  = line_q[9:0];
  wire [9:0] bo_thr  = line_q[25:16];
  wire [9:0] fb_ref  = ref_q[9:0];
  wire [3:0] vs_skip = ref_q[19:16];
  wire [11:0] dcm_off = ref_q[31:20];

  wire in_ss   = (sup_q == S_SS);
  wire running = in_ss | (sup_q == S_RUN);
  wire uvp_low = fb_adc < uvp_thr;
  // A fault cuts the gate at once, before the supervisor has left run
  wire stop_now = ~running | hold_q | surge_hold_q | surge_s | (|f_q) | (|f_set);

  // Two-flop synchronisers for all comparator pins
  always @(posedge clk) begin
    if (rst) begin
      s1_q      <= 6'h00;
      s2_q      <= 6'h00;
      zc_prev_q <= 1'b0;
    end else begin
      s1_q      <= {surge_cmp, zero_cross_cmp, hard_limit_cmp,
                    cycle_limit_cmp, ramp_enhanced_on_time_cmp, ovp_cmp};
      s2_q      <= s1_q;
      zc_prev_q <= zc_s;
    end
  end

  // Register writes
  always @(posedge clk) begin
    if (rst) begin
      ctrl_q   <= `CTRL_RST;
      ramp_enhanced_on_time_q  <= `RAMP_ENHANCED_ON_TIME_RST;
      zc_q     <= `ZC_RST;
      fblim_q  <= `FBLIM_RST;
      line_q   <= `LINE_RST;
      ton_r_q  <= `TON_RST;
      mode_r_q <= `MODE_RST;
      ref_q    <= `REF_RST;
    end else if (wr) begin
      case (addr)
        `A_CTRL:  ctrl_q   <= wdata;
        `A_RAMP_ENHANCED_ON_TIME: ramp_enhanced_on_time_q  <= wdata;
        `A_ZC:    zc_q     <= wdata;
        `A_FBLIM: fblim_q  <= wdata;
        `A_LINE:  line_q   <= wdata;
        `A_TON:   ton_r_q  <= wdata;
        `A_MODE:  mode_r_q <= wdata;
        `A_REF:   ref_q    <= wdata;
        default:  ctrl_q   <= ctrl_q;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rst | ~rd) begin
      rdata <= 32'h00000000;
    end else begin
      case (addr)
        `A_CTRL:  rdata <= ctrl_q;
        `A_RAMP_ENHANCED_ON_TIME: rdata <= ramp_enhanced_on_time_q;
        `A_ZC:    rdata <= zc_q;
        `A_FBLIM: rdata <= fblim_q;
        `A_LINE:  rdata <= line_q;
        `A_TON:   rdata <= ton_r_q;
        `A_MODE:  rdata <= mode_r_q;
        `A_REF:   rdata <= ref_q;
        `A_STAT:  rdata <= {8'h00, mode_q, gst_q, sup_q, line_ok_q, surge_flag_q,
                            1'b0, lat_q, 1'b0, f_q};
        `A_MEAS:  rdata <= {6'h00, vin_peak_q, 4'h0, ton_q};
        default:  rdata <= 32'h00000000;
      endcase
    end
  end

  // On-time from feedback error and line peak
  wire [11:0] fb_err = (fb_ref > fb_adc) ? {2'b00, fb_ref - fb_adc} : 12'h000;
  wire [12:0] t_sum  = {1'b0, ton_r_q[11:0]} + {1'b0, fb_err};
  wire [12:0] vp_sh  = {5'h00, vin_peak_q[9:2]};
  wire [12:0] t_net  = (t_sum > vp_sh) ? t_sum - vp_sh : 13'h0001;
  wire [11:0] ton_calc = t_net[12] ? 12'hFFF : t_net[11:0];
  wire [6:0]  dac_sum  = {1'b0, ramp_enhanced_on_time_dac} + {1'b0, ramp_enhanced_on_time_q[13:8]};

  // Line peak, on-time, mode and ramp code updates
  always @(posedge clk) begin
    if (rst) begin
      vin_peak_q <= 10'h000;
      ton_q      <= 12'h001;
      mode_q     <= M_TM;
      ramp_enhanced_on_time_dac  <= 6'h00;
    end else begin
      if (line_peak)
        vin_peak_q <= vac_adc;
      if (line_valley) begin
        ton_q <= ton_calc;
        // Short on-time means light load: skip valleys, then go discontinuous
        if (ton_calc < mode_r_q[27:16])
          mode_q <= M_DCM;
        else if (ton_calc < mode_r_q[11:0])
          mode_q <= M_VS;
        else
          mode_q <= M_TM;
        ramp_enhanced_on_time_dac <= ramp_enhanced_on_time_q[5:0];
      end else if (cyc_ev) begin
        ramp_enhanced_on_time_dac <= dac_sum[6] ? 6'h3F : dac_sum[5:0];
      end
    end
  end

  // Gate machine: next state and cycle events
  always @* begin
    gst_d      = gst_q;
    cnt_d      = (cnt_q == 12'hFFF) ? cnt_q : cnt_q + 12'h001;
    skip_d     = skip_q;
    cyc_ev     = 1'b0;
    cs_lo_ev   = 1'b0;
    cs_hi_ev   = 1'b0;
    zc_miss_ev = 1'b0;
    zc_ok_ev   = 1'b0;
    case (mode_q)
      M_VS:    start_ok = zc_fall & (skip_q >= vs_skip);
      M_DCM:   start_ok = cnt_q >= dcm_off;
      default: start_ok = zc_fall;
    endcase
    case (gst_q)
      G_WAIT: begin
        if (stop_now) begin
          gst_d = G_HOLD;
        end else if (start_ok | (cnt_q == `ZC_WAIT_MAX)) begin
          // Missing zero-cross restarts the cycle anyway
          gst_d      = G_PRE;
          cnt_d      = 12'h000;
          skip_d     = 4'h0;
          zc_miss_ev = ~start_ok;
          zc_ok_ev   = start_ok;
          cs_hi_ev   = cl_s;
        end else if (zc_fall) begin
          skip_d = skip_q + 4'h1;
        end
      end
      G_PRE: begin
        if (stop_now | hl_s) begin
          gst_d = G_HOLD;
        end else if (cl_s) begin
          gst_d  = G_WAIT;
          cnt_d  = 12'h000;
          cyc_ev = 1'b1;
        end else if (ramp_enhanced_on_time_s) begin
          gst_d = G_TON;
          cnt_d = 12'h000;
        end else if (cnt_q == `RAMP_ENHANCED_ON_TIME_WAIT) begin
          gst_d    = G_WAIT;
          cnt_d    = 12'h000;
          cyc_ev   = 1'b1;
          cs_lo_ev = 1'b1;
        end
      end
      G_TON: begin
        if (stop_now | hl_s) begin
          gst_d = G_HOLD;
        end else if (cl_s | (cnt_q >= ton_q)) begin
          gst_d  = G_WAIT;
          cnt_d  = 12'h000;
          cyc_ev = 1'b1;
        end
      end
      G_HOLD: begin
        if (~stop_now) begin
          gst_d = G_WAIT;
          cnt_d = 12'h000;
        end
      end
      default: gst_d = G_HOLD;
    endcase
  end

  // Gate machine registers; gate follows the next state, enables follow the supervisor run states
  always @(posedge clk) begin
    if (rst) begin
      gst_q             <= G_HOLD;
      cnt_q             <= 12'h000;
      skip_q            <= 4'h0;
      boost_gate_output <= 1'b0;
      cs_cmp_en         <= 1'b0;
      zc_cmp_en         <= 1'b0;
      zc_rise_thr       <= 8'h00;
      zc_fall_thr       <= 8'h00;
    end else begin
      gst_q             <= gst_d;
      cnt_q             <= cnt_d;
      skip_q            <= skip_d;
      boost_gate_output <= (gst_d == G_PRE) | (gst_d == G_TON);
      cs_cmp_en         <= running;
      zc_cmp_en         <= running;
      zc_rise_thr       <= zc_q[7:0];
      zc_fall_thr       <= zc_q[15:8];
    end
  end

  // Half-cycle holds: hard limit, firmware overvoltage and surge
  always @(posedge clk) begin
    if (rst) begin
      hold_q       <= 1'b0;
      hl_seen_q    <= 1'b0;
      surge_hold_q <= 1'b0;
      surge_flag_q <= 1'b0;
      surge_event  <= 1'b0;
    end else begin
      // Set wins over the valley release
      // Hard trip counts even when its sync delay lands after the cycle cut
      hold_q <= (running & (hl_s | (fb_adc >= fw_ovp))) |
                (hold_q & ~line_valley);
      hl_seen_q <= hl_s | (hl_seen_q & ~line_valley);
      // Resume at a half cycle only when the surge line is low
      surge_hold_q <= surge_s | (surge_hold_q & ~line_valley);
      surge_flag_q <= surge_s |
                      (surge_flag_q & ~(wr & (addr == `A_STAT) & wdata[`ST_SURGE]));
      surge_event  <= surge_s |
                      (surge_flag_q & ~(wr & (addr == `A_STAT) & wdata[`ST_SURGE]));
    end
  end

  // Brown-in, brown-out and the half-cycle below brown-out
  always @(posedge clk) begin
    if (rst) begin
      line_ok_q <= 1'b0;
      bo_half_q <= 1'b0;
      bo_cnt_q  <= 25'h0000000;
    end else begin
      if (line_peak) begin
        bo_half_q <= vac_adc < bo_thr;
        if (vac_adc >= bi_thr)
          line_ok_q <= 1'b1;
      end
      if (~bo_half_q) begin
        bo_cnt_q <= 25'h0000000;
      end else if (bo_cnt_q == BO_CYC - 25'h0000001) begin
        line_ok_q <= 1'b0;
      end else begin
        bo_cnt_q <= bo_cnt_q + 25'h0000001;
      end
    end
  end

  // Soft-start and undervoltage timers
  always @(posedge clk) begin
    if (rst) begin
      ss_cnt_q  <= 25'h0000000;
      uvp_cnt_q <= 25'h0000000;
    end else begin
      ss_cnt_q  <= (in_ss & (ss_cnt_q != SS_CYC)) ? ss_cnt_q + 25'h0000001 :
                   (in_ss ? ss_cnt_q : 25'h0000000);
      uvp_cnt_q <= ((sup_q == S_RUN) & uvp_low & (uvp_cnt_q != UVP_CYC)) ?
                   uvp_cnt_q + 25'h0000001 :
                   (((sup_q == S_RUN) & uvp_low) ? uvp_cnt_q : 25'h0000000);
    end
  end

  // Consecutive event counters for hard limit and disconnection checks
  always @(posedge clk) begin
    if (rst | ~running) begin
      ocp_n_q <= 8'h00;
      fbd_n_q <= 4'h0;
      csl_n_q <= 4'h0;
      csh_n_q <= 4'h0;
      zcd_n_q <= 4'h0;
    end else begin
      if (line_valley)
        ocp_n_q <= hl_seen_q ? ocp_n_q + 8'h01 : 8'h00;
      if (cyc_ev)
        fbd_n_q <= (fb_adc < `FB_STUCK) ? fbd_n_q + 4'h1 : 4'h0;
      if (cyc_ev)
        csl_n_q <= cs_lo_ev ? csl_n_q + 4'h1 : 4'h0;
      if (zc_ok_ev | zc_miss_ev) begin
        csh_n_q <= cs_hi_ev ? csh_n_q + 4'h1 : 4'h0;
        zcd_n_q <= zc_miss_ev ? zcd_n_q + 4'h1 : 4'h0;
      end
    end
  end

  // Fault set, latch choice and valley release of the others
  always @* begin
    f_set = 7'h00;
    f_lat = 7'h00;
    f_set[`F_OVP] = running & ovp_s;
    f_lat[`F_OVP] = ctrl_q[`CTRL_OVPL];
    f_set[`F_OCP] = running & line_valley & hl_seen_q &
                    (ocp_n_q >= ton_r_q[23:16]);
    f_lat[`F_OCP] = ctrl_q[`CTRL_OCPL];
    f_set[`F_SS]  = in_ss & (ss_cnt_q == SS_CYC);
    f_set[`F_UVP] = (sup_q == S_RUN) & ((uvp_cnt_q == UVP_CYC) |
                    (ctrl_q[`CTRL_ADAPT] & uvp_low & bo_half_q));
    f_set[`F_FBD] = disc_en & running & (fbd_n_q == `DISC_COUNT);
    f_lat[`F_FBD] = 1'b1;
    f_set[`F_CSD] = disc_en & running & ((in_ss & (csl_n_q == `DISC_COUNT)) |
                    (csh_n_q == `DISC_COUNT));
    f_lat[`F_CSD] = in_ss;
    f_set[`F_ZCD] = disc_en & in_ss & (zcd_n_q == `DISC_COUNT);
    f_lat[`F_ZCD] = 1'b1;
    // Non-latched bits drop at a valley once their cause is gone
    f_clr = line_valley ? ~lat_q : 7'h00;
    f_clr[`F_OVP] = f_clr[`F_OVP] & ~ovp_s;
    f_clr[`F_UVP] = f_clr[`F_UVP] & ~uvp_low;
  end

  always @(posedge clk) begin
    if (rst) begin
      f_q   <= 7'h00;
      lat_q <= 7'h00;
      fault <= 1'b0;
    end else begin
      f_q   <= f_set | (f_q & ~f_clr);
      lat_q <= (f_set & f_lat) | lat_q;
      fault <= |(f_set | (f_q & ~f_clr));
    end
  end

  // Supervisor machine, coupled to the gate machine through stop_now
  always @(posedge clk) begin
    if (rst) begin
      sup_q <= S_STOP;
    end else begin
      case (sup_q)
        S_STOP: begin
          if (|f_q)
            sup_q <= S_FLT;
          else if (en & line_ok_q)
            sup_q <= S_SS;
        end
        S_SS: begin
          if (|f_q)
            sup_q <= S_FLT;
          else if (~en | ~line_ok_q)
            sup_q <= S_STOP;
          else if (fb_adc >= fb_ref)
            sup_q <= S_RUN;
        end
        S_RUN: begin
          if (|f_q)
            sup_q <= S_FLT;
          else if (~en | ~line_ok_q)
            sup_q <= S_STOP;
        end
        S_FLT: begin
          if (~|f_q)
            sup_q <= S_STOP;
        end
        default: sup_q <= S_STOP;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: bench/pfc_gate_assertions.sv
// Checker for gate cut-off, surge flag and zero-cross threshold copies
`timescale 1ns/1ns
`default_nettype none
module pfc_gate_checker (
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  // Comparators and line
  input wire logic        cycle_limit_cmp,
  input wire logic        hard_limit_cmp,
  input wire logic        surge_cmp,
  input wire logic        line_valley,
  // Watched outputs
  input wire logic        boost_gate_output,
  input wire logic [7:0]  zc_rise_thr,
  input wire logic [7:0]  zc_fall_thr,
  input wire logic        fault,
  input wire logic        surge_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Two sync flops plus the gate flop: three samples of a trip are enough
  cycle_cut_a: assert property (cycle_limit_cmp [*3] |=> !boost_gate_output)
    else $error("gate still on after cycle limit");
  hard_cut_a: assert property (hard_limit_cmp [*3] |=> !boost_gate_output)
    else $error("gate still on after hard limit");
  hard_hold_a: assert property (
    hard_limit_cmp [*3] ##1 (!line_valley) [*8] |=> !boost_gate_output)
    else $error("gate back on before line valley");
  fault_gate_a: assert property (fault && $past(fault) |-> !boost_gate_output)
    else $error("gate on during fault");
  surge_cut_a: assert property (surge_cmp [*3] |=> !boost_gate_output && surge_event)
    else $error("surge did not stop gate");
  surge_keep_a: assert property (
    surge_event && !(wr && addr == 4'h8 && wdata[16]) |=> surge_event)
    else $error("surge flag lost");
  surge_clear_a: assert property (
    (!surge_cmp) [*3] ##0 (wr && addr == 4'h8 && wdata[16]) |=> !surge_event)
    else $error("surge flag not cleared");
  zc_rise_a: assert property (
    wr && addr == 4'h2 |-> ##2 zc_rise_thr == $past(wdata[7:0], 2))
    else $error("rise threshold not copied");
  zc_fall_a: assert property (
    wr && addr == 4'h2 |-> ##2 zc_fall_thr == $past(wdata[15:8], 2))
    else $error("fall threshold not copied");
endmodule
bind pfc_gate_and_fault_control pfc_gate_checker u_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
  .cycle_limit_cmp(cycle_limit_cmp), .hard_limit_cmp(hard_limit_cmp),
  .surge_cmp(surge_cmp), .line_valley(line_valley),
  .boost_gate_output(boost_gate_output), .zc_rise_thr(zc_rise_thr),
  .zc_fall_thr(zc_fall_thr), .fault(fault), .surge_event(surge_event)
);
`default_nettype wire

// File: bench/pfc_power_stage.sv
// Behavioural boost stage: inductor current, sense comparators and line timing
`timescale 1ns/1ns
`default_nettype none
module pfc_power_stage (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Knobs and gate drive
  input  wire logic [7:0]  slope,
  input  wire logic [15:0] half_cyc,
  input  wire logic        gate,
  input  wire logic [5:0]  ramp_enhanced_on_time_dac,
  // Comparators and line events
  output logic             ramp_enhanced_on_time_cmp,
  output logic             cycle_limit_cmp,
  output logic             hard_limit_cmp,
  output logic             zero_cross_cmp,
  output logic             line_peak,
  output logic             line_valley
);
  logic [11:0] cur_q;  // Sense voltage in mV
  logic [15:0] ph_q;   // Position in line half cycle
  logic [5:0]  ring_q; // Drain ringing once demagnetised
  // Current ramps while on, decays while off; a big slope mimics a spike
  always @(posedge clk) begin
    if (rst) begin
      cur_q  <= 12'h000;
      ph_q   <= 16'h0000;
      ring_q <= 6'h00;
    end else begin
      if (gate) cur_q <= (cur_q > 12'hE00) ? cur_q : cur_q + {4'h0, slope};
      else cur_q <= (cur_q > {4'h0, slope}) ? cur_q - {4'h0, slope} : 12'h000;
      ph_q   <= (ph_q >= half_cyc - 16'h0001) ? 16'h0000 : ph_q + 16'h0001;
      ring_q <= ring_q + 6'h01;
    end
  end
  // Threshold comparators on the sense voltage
  assign ramp_enhanced_on_time_cmp       = cur_q >= {5'h00, ramp_enhanced_on_time_dac, 1'b0};
  assign cycle_limit_cmp = cur_q > 12'd500;
  assign hard_limit_cmp  = cur_q > 12'd900;
  // Winding high while current flows, then rings so valleys keep coming
  assign zero_cross_cmp  = gate || (cur_q != 12'h000) || ring_q[5];
  // Valley opens each half cycle, peak sits midway
  assign line_valley     = (ph_q == 16'h0000);
  assign line_peak       = (ph_q == (half_cyc >> 1));
endmodule
`default_nettype wire

// File: bench/pfc_gate_and_fault_control_test.sv
// Self-checking bench for the PFC gate and fault block
`timescale 1ns/1ns
`default_nettype none
module pfc_gate_and_fault_control_test;
  logic clk, rst, wr, rd, overvoltage_protection, surge, gate, rc, cl, hl, zc, pk, vl, cs_en, zc_en, flt, sev;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata;
  logic [9:0]  fb, vac;
  logic [7:0]  slope, zr, zf;
  logic [5:0]  dac;
  logic [15:0] half;
  int          error_cnt = 0;
  int          checks = 0;
  // Short counts keep the run brief
  pfc_gate_and_fault_control #(.SS_CYC(25'd200), .UVP_CYC(25'd50), .BO_CYC(25'd40)) dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ovp_cmp(overvoltage_protection), .ramp_enhanced_on_time_cmp(rc), .cycle_limit_cmp(cl), .hard_limit_cmp(hl),
    .zero_cross_cmp(zc), .surge_cmp(surge), .fb_adc(fb), .vac_adc(vac), .line_peak(pk),
    .line_valley(vl), .boost_gate_output(gate), .ramp_enhanced_on_time_dac(dac), .zc_rise_thr(zr),
    .zc_fall_thr(zf), .cs_cmp_en(cs_en), .zc_cmp_en(zc_en), .fault(flt), .surge_event(sev));
  pfc_power_stage stage (
    .clk(clk), .rst(rst), .slope(slope), .half_cyc(half), .gate(gate), .ramp_enhanced_on_time_dac(dac),
    .ramp_enhanced_on_time_cmp(rc), .cycle_limit_cmp(cl), .hard_limit_cmp(hl), .zero_cross_cmp(zc),
    .line_peak(pk), .line_valley(vl));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Extra edge at the end so back-to-back calls never rewrite the strobe
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic wait_on(ref logic s, input logic lvl, input int n);
    for (int i = 0; i < n && s !== lvl; i++) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_reset;
    logic [31:0] d;
    logic [31:0] rv [8] = '{32'h0E, 32'h104, 32'h2040, 32'h00C003A0, 32'h00A000C0,
                            32'h00030100, 32'h00300260, 32'h00020380};
    for (int i = 0; i < 8; i++) begin
      rd_reg(i[3:0], d);
      check("reset value", d, rv[i]);
    end
    // Last read was nonzero: data must be gone one cycle later
    #1 check("read data idle", rdata, 32'h0);
    // First valley after reset loads the base code
    check("ramp code at valley", {26'h0, dac}, 32'h04);
    rd_reg(4'hA, d);
    check("unmapped read", d, 32'h0);
    check("rise thr", {24'h0, zr}, 32'h40);
    wr_reg(4'h2, 32'h3355);
    @(posedge clk); #1;
    check("rise thr set", {24'h0, zr}, 32'h55);
    check("fall thr set", {24'h0, zf}, 32'h33);
    $display("test reset done");
  endtask
  task automatic t_run;
    logic [31:0] d;
    wr_reg(4'h0, 32'h0F);
    wait_on(gate, 1'b1, 3000);
    check("gate pulse", gate, 1'b1);
    check("comparator enables", {cs_en, zc_en}, 2'b11);
    rd_reg(4'h8, d);
    check("line ok", d[17], 1'b1);
    rd_reg(4'h9, d);
    check("line peak", d[25:16], 10'h200);
    wait_on(vl, 1'b1, 700);
    repeat (3) @(posedge clk);
    fb <= 10'h370;
    rd_reg(4'h9, d);
    check("on-time held", d[11:0], 12'h080);
    wait_on(vl, 1'b1, 700);
    repeat (3) @(posedge clk);
    rd_reg(4'h9, d);
    check("on-time at valley", d[11:0], 12'h090);
    fb <= 10'h380;
    $display("test run done");
  endtask
  task automatic t_hard;
    logic [31:0] d;
    int          rises;
    slope <= 8'd200;
    wait_on(gate, 1'b1, 1500);
    wait_on(gate, 1'b0, 50);
    rises = 0;
    while (vl !== 1'b1) begin
      @(posedge clk); #1;
      if (gate === 1'b1) rises++;
    end
    check("off until valley", rises, 0);
    wait_on(flt, 1'b1, 4000);
    check("hard fault", flt, 1'b1);
    rd_reg(4'h8, d);
    check("hard fault bits", {d[9], d[1]}, 2'b11);
    slope <= 8'd1;
    repeat (1300) @(posedge clk);
    check("latched fault holds", flt, 1'b1);
    check("enables off in fault", {cs_en, zc_en}, 2'b00);
    do_reset;
    check("reset clears", flt, 1'b0);
    $display("test hard limit done");
  endtask
  task automatic t_ovp_surge;
    logic [31:0] d;
    wr_reg(4'h0, 32'h0D);
    wait_on(gate, 1'b1, 3000);
    overvoltage_protection <= 1'b1;
    repeat (5) @(posedge clk);
    rd_reg(4'h8, d);
    check("ovp fault bits", {d[8], d[0]}, 2'b01);
    overvoltage_protection <= 1'b0;
    repeat (1300) @(posedge clk);
    check("ovp auto clear", flt, 1'b0);
    wait_on(gate, 1'b1, 1500);
    surge <= 1'b1;
    repeat (5) @(posedge clk);
    check("surge gate off", {gate, sev}, 2'b01);
    wr_reg(4'h8, 32'h10000);
    check("surge set wins", sev, 1'b1);
    surge <= 1'b0;
    repeat (4) @(posedge clk);
    wr_reg(4'h8, 32'h10000);
    check("surge cleared", sev, 1'b0);
    $display("test ovp and surge done");
  endtask
  task automatic t_uvp;
    logic [31:0] d;
    wait_on(gate, 1'b1, 1500);
    fb <= 10'h050;
    repeat (30) @(posedge clk);
    check("uvp early", flt, 1'b0);
    repeat (60) @(posedge clk);
    rd_reg(4'h8, d);
    check("uvp fault", d[3], 1'b1);
    $display("test uvp done");
  endtask
  // Main sequence
  initial begin
    rst = 1'b1; addr = 4'h0; wdata = 32'h0; wr = 1'b0; rd = 1'b0; overvoltage_protection = 1'b0;
    surge = 1'b0; fb = 10'h380; vac = 10'h200; slope = 8'd1; half = 16'd600;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_run;
    t_hard;
    t_ovp_surge;
    t_uvp;
    wrap_up;
  end
  // Watchdog well beyond the expected span of all tests
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("ERROR watchdog expired");
    wrap_up;
  end
endmodule
`default_nettype wire
